/* design/cefe_pkg.sv */
// Shared constants of the character field edit engine: widths,
// character codes, zone layout and operand form encodings.
// Assumes a six-bit character memory with one word-mark bit per location.
package cefe_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int CHAR_W = 6;

	// ------------------------------------------------------------
	// character field layout
	// ------------------------------------------------------------
	localparam int ZONE_HI = 5;
	localparam int ZONE_LO = 4;
	localparam int NUM_HI = 3;
	localparam logic [1:0] ZONE_CLEAR = 2'h0;
	localparam logic [1:0] ZONE_NEG = 2'h2;

	// ------------------------------------------------------------
	// character codes with an editing meaning
	// ------------------------------------------------------------
	localparam logic [CHAR_W-1:0] CH_ZERO = 6'h00;
	localparam logic [CHAR_W-1:0] CH_ONE = 6'h01;
	localparam logic [CHAR_W-1:0] CH_NINE = 6'h09;
	localparam logic [CHAR_W-1:0] CH_BLANK = 6'h10;
	localparam logic [CHAR_W-1:0] CH_FILL37 = 6'h1f;
	localparam logic [CHAR_W-1:0] CH_POINT = 6'h1b;
	localparam logic [CHAR_W-1:0] CH_COMMA = 6'h3b;
	localparam logic [CHAR_W-1:0] CH_ASTERISK = 6'h2c;
	localparam logic [CHAR_W-1:0] CH_DOLLAR = 6'h2b;
	localparam logic [CHAR_W-1:0] CH_MINUS = 6'h20;
	localparam logic [CHAR_W-1:0] CH_CREDIT = 6'h3c;

	// ------------------------------------------------------------
	// operand forms of the move_and_edit_instruction
	// ------------------------------------------------------------
	localparam logic [1:0] FORM_A = 2'h0;
	localparam logic [1:0] FORM_B = 2'h1;
	localparam logic [1:0] FORM_C = 2'h2;

	// ------------------------------------------------------------
	// address step
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;

endpackage

/* design/cefe_char_class.sv */
// Combinational classifier for one six-bit character.
// Assumes the character codes of the package.
module cefe_char_class
	import cefe_pkg::*;
(
	// character to classify
	input wire logic [cefe_pkg::CHAR_W-1:0] ch,
	// class flags
	output logic is_blank,
	output logic is_zero,
	output logic is_comma,
	output logic is_point,
	output logic is_star,
	output logic is_dollar,
	output logic is_sign,
	output logic is_fill37,
	output logic is_sig_digit
);
	// plain compares against the edit character codes
	always_comb begin
		is_blank = (ch == CH_BLANK);
		is_zero = (ch == CH_ZERO);
		is_comma = (ch == CH_COMMA);
		is_point = (ch == CH_POINT);
		is_star = (ch == CH_ASTERISK);
		is_dollar = (ch == CH_DOLLAR);
		is_sign = (ch == CH_MINUS) || (ch == CH_CREDIT);
		is_fill37 = (ch == CH_FILL37);
		is_sig_digit = (ch >= CH_ONE) && (ch <= CH_NINE);
	end
endmodule

/* design/cefe_operand_sel.sv */
// Chooses the source and destination field addresses by operand form.
// Assumes the address registers are stable while the start is taken.
module cefe_operand_sel
	import cefe_pkg::*;
(
	// form and address sources
	input wire logic [1:0] form,
	input wire logic [cefe_pkg::ADDR_W-1:0] instr_a,
	input wire logic [cefe_pkg::ADDR_W-1:0] instr_b,
	input wire logic [cefe_pkg::ADDR_W-1:0] src_reg,
	input wire logic [cefe_pkg::ADDR_W-1:0] dst_reg,
	// chosen rightmost addresses
	output logic [cefe_pkg::ADDR_W-1:0] a_addr,
	output logic [cefe_pkg::ADDR_W-1:0] b_addr
);
	// form a uses the instruction, b the destination register, c both
	always_comb begin
		a_addr = (form == FORM_C) ? src_reg : instr_a;
		b_addr = (form == FORM_A) ? instr_b : dst_reg;
	end
endmodule

/* design/cefe_engine.sv */
// Character field edit engine: moves a source field into a destination
// field that already holds an edit control word, then suppresses zeros
// and floats the currency sign as the control word asks.
// Assumes memory answers reads combinationally in the cycle the address
// stands and writes at the clock edge while the write enable is high.
// Summary of operation
// - copy source into destination, formatted by control word
// - destination high-order word mark bounds the edit
// - move right to left, end at mark
// - suppression scan blanks high-order zeros and commas
// - scan stops at digit, point, symbol position
// - asterisk left of symbol fills with asterisks
// - currency left of symbol floats after suppression
// - blanks take source characters, right aligned
// - suppression symbol is limit and takes data
// - characters without meaning stay where written
// - commas left of moved data become blanks
// - sign symbols kept if negative, else blanked
// - octal 37 becomes a blank
// - forms b and c take address registers
// - source word mark stops source transfer
// - destination mark cleared when it ended edit, kept when zeros are suppressed without float
// - mark set at symbol, erased on scan
// - units character zone bits forced to zero
module cefe_engine
	import cefe_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// instruction start and operands
	input wire logic START,
	input wire logic [1:0] FORM,
	input wire logic [cefe_pkg::ADDR_W-1:0] INSTR_A_ADDR,
	input wire logic [cefe_pkg::ADDR_W-1:0] INSTR_B_ADDR,
	input wire logic [cefe_pkg::ADDR_W-1:0] SOURCE_ADDRESS_REGISTER,
	input wire logic [cefe_pkg::ADDR_W-1:0] DEST_ADDRESS_REGISTER,
	// status
	output logic BUSY,
	output logic DONE,
	// memory port
	output logic [cefe_pkg::ADDR_W-1:0] MEM_ADDR,
	output logic MEM_WE,
	output logic [cefe_pkg::CHAR_W-1:0] MEM_WDATA,
	output logic MEM_WWM,
	input wire logic [cefe_pkg::CHAR_W-1:0] MEM_RDATA,
	input wire logic MEM_RWM
);
	import cefe_pkg::*;

	// ------------------------------------------------------------
	// state and working registers
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_SIGN,
		ST_MV_B,
		ST_MV_A,
		ST_MV_W,
		ST_SUP_R,
		ST_SUP_W,
		ST_FLT_W,
		ST_FLT_C
	} cefe_state_t;

	cefe_state_t state, next_state;
	logic [ADDR_W-1:0] a_ptr, b_ptr, b_left, z_addr, sig_addr;
	logic [ADDR_W-1:0] next_a_ptr, next_b_ptr, next_b_left, next_z_addr;
	logic [ADDR_W-1:0] next_sig_addr, next_mem_addr;
	logic has_sup, flt_mode, ast_mode, prev_zero, src_done, first_src;
	logic neg, at_left, stopped, hold_wm;
	logic next_has_sup, next_flt_mode, next_ast_mode, next_prev_zero;
	logic next_src_done, next_first_src, next_neg, next_at_left;
	logic next_stopped, next_hold_wm, next_mem_we, next_mem_wwm, next_done;
	logic [CHAR_W-1:0] next_mem_wdata;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] sel_a, sel_b;
	logic c_blank, c_zero, c_comma, c_point, c_star;
	logic c_dollar, c_sign, c_fill37, c_sig;

	// operand addresses by form
	cefe_operand_sel u_sel (
		.form(FORM),
		.instr_a(INSTR_A_ADDR),
		.instr_b(INSTR_B_ADDR),
		.src_reg(SOURCE_ADDRESS_REGISTER),
		.dst_reg(DEST_ADDRESS_REGISTER),
		.a_addr(sel_a),
		.b_addr(sel_b)
	);

	// class of the character on the read bus
	cefe_char_class u_class (
		.ch(MEM_RDATA),
		.is_blank(c_blank),
		.is_zero(c_zero),
		.is_comma(c_comma),
		.is_point(c_point),
		.is_star(c_star),
		.is_dollar(c_dollar),
		.is_sign(c_sign),
		.is_fill37(c_fill37),
		.is_sig_digit(c_sig)
	);

	// busy whenever the sequencer has left idle
	assign BUSY = (state != ST_IDLE);

	// ------------------------------------------------------------
	// next-state and datapath decisions
	// ------------------------------------------------------------
	logic at_dollar, at_star, repl, sup_eff, flt_eff;
	logic [CHAR_W-1:0] fill_ch;

	// one access per state, each address and write set up one cycle ahead
	always_comb begin
		next_state = state;
		next_a_ptr = a_ptr;
		next_b_ptr = b_ptr;
		next_b_left = b_left;
		next_z_addr = z_addr;
		next_sig_addr = sig_addr;
		next_has_sup = has_sup;
		next_flt_mode = flt_mode;
		next_ast_mode = ast_mode;
		next_prev_zero = prev_zero;
		next_src_done = src_done;
		next_first_src = first_src;
		next_neg = neg;
		next_at_left = at_left;
		next_stopped = stopped;
		next_hold_wm = hold_wm;
		next_mem_addr = MEM_ADDR;
		next_mem_we = 1'b0;
		next_mem_wdata = MEM_WDATA;
		next_mem_wwm = MEM_WWM;
		next_done = 1'b0;
		at_dollar = prev_zero && c_dollar;
		at_star = prev_zero && c_star;
		repl = c_blank || c_zero || at_dollar;
		sup_eff = has_sup || c_zero;
		flt_eff = flt_mode || at_dollar;
		fill_ch = ast_mode ? CH_ASTERISK : CH_BLANK;
		unique case (state)
			ST_IDLE: begin
				if (START) begin
					next_a_ptr = sel_a;
					next_b_ptr = sel_b;
					next_has_sup = 1'b0;
					next_flt_mode = 1'b0;
					next_ast_mode = 1'b0;
					next_prev_zero = 1'b0;
					next_src_done = 1'b0;
					next_first_src = 1'b1;
					next_at_left = 1'b0;
					next_stopped = 1'b0;
					next_mem_addr = sel_a;
					next_state = ST_SIGN;
				end
			end
			ST_SIGN: begin
				// units sign is needed before any sign symbol is met
				next_neg = (MEM_RDATA[ZONE_HI:ZONE_LO] == ZONE_NEG);
				next_mem_addr = b_ptr;
				next_state = ST_MV_B;
			end
			ST_MV_B: begin
				// control character at b_ptr, right to left
				next_prev_zero = c_zero;
				next_at_left = MEM_RWM;
				next_b_left = MEM_RWM ? b_ptr : b_left;
				next_has_sup = sup_eff;
				next_flt_mode = flt_eff;
				next_ast_mode = ast_mode || at_star;
				// symbol location gets a mark; left mark kept only if needed
				if (c_zero) begin
					next_z_addr = b_ptr;
					next_hold_wm = 1'b1;
				end else begin
					next_hold_wm = MEM_RWM && sup_eff && !flt_eff;
				end
				if (repl && !src_done) begin
					next_mem_addr = a_ptr;
					next_state = ST_MV_A;
				end else begin
					next_mem_addr = b_ptr;
					next_mem_we = 1'b1;
					next_mem_wwm = next_hold_wm;
					// exhausted blanks and commas left of the data go blank
					if (repl || (c_comma && src_done)) begin
						next_mem_wdata = CH_BLANK;
					end else if ((c_sign && !neg) || c_fill37) begin
						next_mem_wdata = CH_BLANK;
					end else begin
						next_mem_wdata = MEM_RDATA;
					end
					next_state = ST_MV_W;
				end
			end
			ST_MV_A: begin
				// source character read, written into the replaceable spot
				next_first_src = 1'b0;
				next_src_done = MEM_RWM;
				next_a_ptr = a_ptr - ADDR_STEP;
				next_mem_addr = b_ptr;
				next_mem_we = 1'b1;
				next_mem_wwm = hold_wm;
				if (first_src) begin
					next_mem_wdata = {ZONE_CLEAR, MEM_RDATA[NUM_HI:0]};
				end else begin
					next_mem_wdata = MEM_RDATA;
				end
				next_state = ST_MV_W;
			end
			ST_MV_W: begin
				// write happens now; pick the next location
				if (at_left) begin
					if (has_sup) begin
						next_b_ptr = b_left;
						next_sig_addr = z_addr;
						next_mem_addr = b_left;
						next_state = ST_SUP_R;
					end else begin
						next_done = 1'b1;
						next_state = ST_IDLE;
					end
				end else begin
					next_b_ptr = b_ptr - ADDR_STEP;
					next_mem_addr = b_ptr - ADDR_STEP;
					next_state = ST_MV_B;
				end
			end
			ST_SUP_R: begin
				// left to right suppression scan
				next_mem_addr = b_ptr;
				if (b_ptr == z_addr) begin
					next_mem_we = 1'b1;
					next_mem_wdata = MEM_RDATA;
					next_mem_wwm = 1'b0;
					next_state = ST_SUP_W;
				end else if (!stopped && (c_sig || c_point)) begin
					next_stopped = 1'b1;
					next_sig_addr = b_ptr;
					next_b_ptr = b_ptr + ADDR_STEP;
					next_mem_addr = b_ptr + ADDR_STEP;
				end else if (!stopped &&
						(c_zero || c_comma || (ast_mode && c_blank))) begin
					next_mem_we = 1'b1;
					next_mem_wdata = fill_ch;
					next_mem_wwm = MEM_RWM;
					next_state = ST_SUP_W;
				end else begin
					next_b_ptr = b_ptr + ADDR_STEP;
					next_mem_addr = b_ptr + ADDR_STEP;
				end
			end
			ST_SUP_W: begin
				if (b_ptr == z_addr) begin
					if (flt_mode) begin
						// currency goes just left of the first significant one
						next_mem_addr = sig_addr - ADDR_STEP;
						next_state = ST_FLT_W;
					end else begin
						next_done = 1'b1;
						next_state = ST_IDLE;
					end
				end else begin
					next_b_ptr = b_ptr + ADDR_STEP;
					next_mem_addr = b_ptr + ADDR_STEP;
					next_state = ST_SUP_R;
				end
			end
			ST_FLT_W: begin
				// a cycle after the symbol write, so writes never run back
				// to back; the left mark already went during the move
				next_mem_we = 1'b1;
				next_mem_wdata = CH_DOLLAR;
				next_mem_wwm = 1'b0;
				next_state = ST_FLT_C;
			end
			ST_FLT_C: begin
				next_done = 1'b1;
				next_state = ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// sequencer state
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// field pointers
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			a_ptr <= '0;
			b_ptr <= '0;
			b_left <= '0;
			z_addr <= '0;
			sig_addr <= '0;
		end else begin
			a_ptr <= next_a_ptr;
			b_ptr <= next_b_ptr;
			b_left <= next_b_left;
			z_addr <= next_z_addr;
			sig_addr <= next_sig_addr;
		end
	end

	// edit mode flags
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			has_sup <= 1'b0;
			flt_mode <= 1'b0;
			ast_mode <= 1'b0;
			prev_zero <= 1'b0;
			src_done <= 1'b0;
			first_src <= 1'b0;
			neg <= 1'b0;
			at_left <= 1'b0;
			stopped <= 1'b0;
			hold_wm <= 1'b0;
		end else begin
			has_sup <= next_has_sup;
			flt_mode <= next_flt_mode;
			ast_mode <= next_ast_mode;
			prev_zero <= next_prev_zero;
			src_done <= next_src_done;
			first_src <= next_first_src;
			neg <= next_neg;
			at_left <= next_at_left;
			stopped <= next_stopped;
			hold_wm <= next_hold_wm;
		end
	end

	// memory port and completion pulse
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			MEM_ADDR <= '0;
			MEM_WE <= 1'b0;
			MEM_WDATA <= '0;
			MEM_WWM <= 1'b0;
			DONE <= 1'b0;
		end else begin
			MEM_ADDR <= next_mem_addr;
			MEM_WE <= next_mem_we;
			MEM_WDATA <= next_mem_wdata;
			MEM_WWM <= next_mem_wwm;
			DONE <= next_done;
		end
	end
endmodule

/* testbench/cefe_engine_checker.sv */
// Port checker of the edit engine: status handshake, memory port shape.
// Bound to cefe_engine; sees only its ports, one clock domain.
module cefe_engine_checker
	import cefe_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// start and operands
	input wire logic START,
	input wire logic [1:0] FORM,
	input wire logic [cefe_pkg::ADDR_W-1:0] INSTR_A_ADDR,
	input wire logic [cefe_pkg::ADDR_W-1:0] INSTR_B_ADDR,
	input wire logic [cefe_pkg::ADDR_W-1:0] SOURCE_ADDRESS_REGISTER,
	input wire logic [cefe_pkg::ADDR_W-1:0] DEST_ADDRESS_REGISTER,
	// status and memory port
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic [cefe_pkg::ADDR_W-1:0] MEM_ADDR,
	input wire logic MEM_WE,
	input wire logic [cefe_pkg::CHAR_W-1:0] MEM_WDATA,
	input wire logic [cefe_pkg::CHAR_W-1:0] MEM_RDATA
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	logic [9:0] busy_cnt;
	logic take;
	assign take = START && !BUSY;
	// length of the running edit, so a hang shows up
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			busy_cnt <= 10'h000;
		end else if (BUSY) begin
			busy_cnt <= busy_cnt + 10'h001;
		end else begin
			busy_cnt <= 10'h000;
		end
	end
	// units char under a blank control char is written with clear zone
	sequence s_blank_units;
		take ##2 MEM_RDATA == CH_BLANK;
	endsequence
	sequence s_units_write;
		MEM_WE && MEM_WDATA[ZONE_HI:ZONE_LO] == ZONE_CLEAR;
	endsequence
	a_busy_starts: assert property (take |=> BUSY)
		else $error("busy did not follow start");
	a_done_shape: assert property (DONE |->
		$past(BUSY) && !BUSY ##1 !DONE)
		else $error("done not a single pulse ending busy");
	a_busy_ends: assert property ($fell(BUSY) |-> DONE)
		else $error("busy fell without done");
	a_busy_bound: assert property (busy_cnt < 10'h1f4)
		else $error("edit ran too long");
	a_idle_write: assert property (!BUSY |-> !MEM_WE)
		else $error("write while idle");
	a_write_pulse: assert property (MEM_WE |=> !MEM_WE)
		else $error("write enable held");
	a_form_a_addr: assert property (take && FORM == FORM_A |=>
		MEM_ADDR == $past(INSTR_A_ADDR) ##1
		MEM_ADDR == $past(INSTR_B_ADDR, 2))
		else $error("form a addresses wrong");
	a_form_b_addr: assert property (take && FORM == FORM_B |=>
		MEM_ADDR == $past(INSTR_A_ADDR) ##1
		MEM_ADDR == $past(DEST_ADDRESS_REGISTER, 2))
		else $error("form b addresses wrong");
	a_form_c_addr: assert property (take && FORM == FORM_C |=>
		MEM_ADDR == $past(SOURCE_ADDRESS_REGISTER) ##1
		MEM_ADDR == $past(DEST_ADDRESS_REGISTER, 2))
		else $error("form c addresses wrong");
	a_units_zone: assert property (s_blank_units |->
		##2 s_units_write)
		else $error("units zone not cleared");
endmodule

/* testbench/cefe_mem_model.sv */
// Character memory at the far side of the edit engine.
// Assumes the bench preloads fields through data and mark.
module cefe_mem_model
	import cefe_pkg::*;
(
	// clock
	input wire logic clk,
	// access from the engine
	input wire logic [cefe_pkg::ADDR_W-1:0] addr,
	input wire logic we,
	input wire logic [cefe_pkg::CHAR_W-1:0] wdata,
	input wire logic wwm,
	// read answer
	output logic [cefe_pkg::CHAR_W-1:0] rdata,
	output logic rwm
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [cefe_pkg::CHAR_W-1:0] data [64];
	logic mark [64];
	// read answers in the cycle the address stands
	assign rdata = data[addr[5:0]];
	assign rwm = mark[addr[5:0]];
	// char and mark of one location updated together
	always @(posedge clk) begin
		if (we) begin
			data[addr[5:0]] <= wdata;
			mark[addr[5:0]] <= wwm;
		end
	end
endmodule

/* testbench/character_field_edit_engine_tb.sv */
// Self-checking bench of the edit engine with a character memory.
// Assumes fields end at their rightmost address, mark at leftmost.
module character_field_edit_engine_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cefe_pkg::*;
	logic REF_CLK, RST_N, START, BUSY, DONE, MEM_WE, MEM_WWM, MEM_RWM;
	logic [1:0] FORM;
	logic [ADDR_W-1:0] INSTR_A_ADDR, INSTR_B_ADDR, MEM_ADDR;
	logic [ADDR_W-1:0] SOURCE_ADDRESS_REGISTER, DEST_ADDRESS_REGISTER;
	logic [CHAR_W-1:0] MEM_WDATA, MEM_RDATA;
	int failures = 0;
	int n_tests = 0;
	cefe_engine dut (.REF_CLK, .RST_N, .START, .FORM, .INSTR_A_ADDR,
		.INSTR_B_ADDR, .SOURCE_ADDRESS_REGISTER, .DEST_ADDRESS_REGISTER,
		.BUSY, .DONE, .MEM_ADDR, .MEM_WE, .MEM_WDATA, .MEM_WWM,
		.MEM_RDATA, .MEM_RWM);
	cefe_mem_model mem (.clk(REF_CLK), .addr(MEM_ADDR), .we(MEM_WE),
		.wdata(MEM_WDATA), .wwm(MEM_WWM), .rdata(MEM_RDATA), .rwm(MEM_RWM));
	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	task automatic chk(input bit ok);
		n_tests++;
		if (!ok) begin
			failures++;
			$display("CHECK FAILED %0t: result mismatch", $time);
		end
	endtask
	// field with its mark on the leftmost char
	task automatic ld(input int a, input logic [5:0] c [$]);
		for (int i = 0; i < c.size(); i++) begin
			mem.data[a - c.size() + 1 + i] = c[i];
			mem.mark[a - c.size() + 1 + i] = (i == 0);
		end
	endtask
	task automatic cmp(input int a, input logic [5:0] c [$], input bit m);
		int b;
		b = a - c.size() + 1;
		for (int i = 0; i < c.size(); i++) begin
			chk(mem.data[b + i] === c[i]);
			chk(mem.mark[b + i] === (m && i == 0));
		end
	endtask
	// start pulse, optional ignored start while busy, bounded wait
	task automatic run(input logic [1:0] f, input logic [14:0] ia, ib,
		sa, da, input bit poke);
		bit ok;
		ok = 0;
		@(negedge REF_CLK);
		FORM = f;
		INSTR_A_ADDR = ia;
		INSTR_B_ADDR = ib;
		SOURCE_ADDRESS_REGISTER = sa;
		DEST_ADDRESS_REGISTER = da;
		START = 1'b1;
		@(negedge REF_CLK);
		START = 1'b0;
		if (poke) begin
			repeat (3) @(negedge REF_CLK);
			START = 1'b1;
			@(negedge REF_CLK);
			START = 1'b0;
		end
		for (int k = 0; k < 400 && !ok; k++) begin
			@(posedge REF_CLK);
			#1 ok = (DONE === 1'b1);
		end
		chk(ok);
	endtask
	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	// move only: blanks, comma, point, minus kept on negative units
	task automatic t_plain();
		ld(10, '{6'h01, 6'h02, 6'h03, 6'h24});
		ld(30, '{6'h10, 6'h3b, 6'h10, 6'h10, 6'h10, 6'h1b, 6'h10, 6'h20});
		run(FORM_A, 15'h000a, 15'h001e, 15'h0003, 15'h0004, 1'b1);
		cmp(30, '{6'h10, 6'h10, 6'h01, 6'h02, 6'h03, 6'h1b, 6'h04, 6'h20},
			1'b0);
		repeat (3) @(posedge REF_CLK);
		#1 chk(BUSY === 1'b0);
	endtask
	// suppression with asterisk fill, credit blanked, code 37 blanked
	task automatic t_asterisk();
		ld(20, '{6'h00, 6'h00, 6'h07, 6'h00, 6'h00, 6'h05});
		ld(42, '{6'h10, 6'h3b, 6'h10, 6'h10, 6'h2c, 6'h00, 6'h1b, 6'h10,
			6'h10, 6'h3c, 6'h1f});
		run(FORM_B, 15'h0014, 15'h0005, 15'h0006, 15'h002a, 1'b0);
		cmp(42, '{6'h2c, 6'h2c, 6'h2c, 6'h07, 6'h2c, 6'h00, 6'h1b,
			6'h00, 6'h05, 6'h10, 6'h10},
			1'b1);
	endtask
	// suppression with floating currency, operands from registers
	task automatic t_float();
		ld(12, '{6'h00, 6'h00, 6'h00, 6'h01, 6'h02, 6'h03, 6'h14});
		ld(60, '{6'h10, 6'h3b, 6'h10, 6'h10, 6'h2b, 6'h00, 6'h1b, 6'h10,
			6'h10});
		run(FORM_C, 15'h0001, 15'h0002, 15'h000c, 15'h003c, 1'b0);
		cmp(60, '{6'h10, 6'h10, 6'h10, 6'h2b, 6'h01, 6'h02, 6'h1b, 6'h03,
			6'h04}, 1'b0);
	endtask
	task automatic finish_test();
		if (failures == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// clock of 10 ns
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	// main sequence; no variant instruction follows an edit
	initial begin
		RST_N = 1'b0;
		START = 1'b0;
		FORM = FORM_A;
		INSTR_A_ADDR = 15'h0000;
		INSTR_B_ADDR = 15'h0000;
		SOURCE_ADDRESS_REGISTER = 15'h0000;
		DEST_ADDRESS_REGISTER = 15'h0000;
		repeat (3) @(negedge REF_CLK);
		RST_N = 1'b1;
		t_plain();
		t_asterisk();
		t_float();
		finish_test();
	end
	// hang guard, well past three edits
	initial begin
		#50000;
		failures++;
		finish_test();
	end
endmodule
bind cefe_engine cefe_engine_checker chk (.REF_CLK, .RST_N, .START, .FORM,
	.INSTR_A_ADDR, .INSTR_B_ADDR, .SOURCE_ADDRESS_REGISTER,
	.DEST_ADDRESS_REGISTER, .BUSY, .DONE, .MEM_ADDR, .MEM_WE, .MEM_WDATA,
	.MEM_RDATA);
